// ---- rtl/ums_cfg.svh ----
`ifndef UMS_CFG_SVH
`define UMS_CFG_SVH
// Byte address layout: channel in bit 5, register index in bits 4:2.
`define UMS_ADDR_CH 5
`define UMS_ADDR_REG_HI 4
`define UMS_ADDR_REG_LO 2
// Register indexes.
`define UMS_REG_DATA 3'h0
`define UMS_REG_IER 3'h1
`define UMS_REG_IIR 3'h2
`define UMS_REG_LCR 3'h3
`define UMS_REG_MCR 3'h4
`define UMS_REG_LSR 3'h5
`define UMS_REG_MSR 3'h6
`define UMS_REG_SCR 3'h7
// Interrupt enable fields.
`define UMS_IER_RX 0
`define UMS_IER_TX 1
`define UMS_IER_LS 2
`define UMS_IER_MS 3
// Line control fields.
`define UMS_LCR_DIVISOR_LATCH_ACCESS 7
`define UMS_LCR_PAR 3
`define UMS_LCR_STOP 2
// Modem control fields.
`define UMS_MCR_DTR 0
`define UMS_MCR_RTS 1
`define UMS_MCR_OUT1 2
`define UMS_MCR_OUT2 3
`define UMS_MCR_LOOP 4
// Alternate function and FIFO control fields.
`define UMS_AFR_CONC 0
`define UMS_AFR_SEL_HI 2
`define UMS_AFR_SEL_LO 1
`define UMS_FCR_EN 0
// Multi-function pin selections.
`define UMS_MF_OUT2 2'h0
`define UMS_MF_BAUD 2'h1
`define UMS_MF_RECEIVE_READY_OUT 2'h2
`define UMS_MF_HIGH 2'h3
// Interrupt identification codes.
`define UMS_IIR_NONE 4'h1
`define UMS_IIR_LS 4'h6
`define UMS_IIR_RDA 4'h4
`define UMS_IIR_TOUT 4'hC
`define UMS_IIR_TX_HOLDING_EMPTY 4'h2
`define UMS_IIR_MS 4'h0
// Reset values.
`define UMS_AFR_RST 3'h0
`define UMS_IER_RST 4'h0
`define UMS_LCR_RST 8'h00
`define UMS_MCR_RST 5'h00
`define UMS_BYTE_RST 8'h00
// Character timing in baud-clock ticks.
`define UMS_TICKS_PER_BIT 16
`define UMS_TOUT_CHARS 4
`define UMS_START_BITS 1
`define UMS_MIN_STOP_BITS 1
`define UMS_WL_BASE 5
`endif

// ---- rtl/ums_pkg.sv ----
package ums_pkg;
  typedef enum logic {UMS_BS_IDLE, UMS_BS_DONE} ums_bus_st_t;
  typedef logic [7:0] ums_byte_t;
endpackage

// ---- rtl/ums_core.sv ----
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
`include "ums_cfg.svh"

// How it works
// R1 - Clear-to-send, set-ready and carrier-detect changes set flags 0, 1 and 3.
// R2 - Ring input rising from low to high sets flag 2.
// R3 - Reading modem status clears the four change flags.
// R4 - Any set change flag raises the modem status interrupt condition.
// R5 - Bits 4 to 7 read the inverted modem input pins.
// R6 - In loopback bits 4 to 7 read modem control outputs instead.
// R7 - Alternate function register sits at index 2 with divisor latch access set.
// R8 - Concurrent bit makes writes reach both channels; reads use channel select.
// R9 - Software equalises divisor latch access in both channels before concurrent writes.
// R10 - Alternate function bits 2:1 choose the multi-function pin source.
// R11 - Alternate function bits 3 to 7 read zero.
// R12 - Scratch register stores and returns any byte, affecting nothing.
// R13 - Received-data indication follows receive count at or above trigger in FIFO mode, non-empty count otherwise.
// R14 - Line status identification outranks received-data identification.
// R15 - Data ready follows a non-empty receive queue.
// R16 - Timeout after four character times without receive or read, queue non-empty.
// R17 - Character times are counted on the baud clock.
// R18 - Read clears timeout; timer restarts on reads, or new characters when idle.
// R19 - Transmit empty interrupt set on empty queue, cleared by data write or ident read.
// R20 - Empty delayed one character less stop in FIFO mode unless two bytes held or first.
// R21 - Without enables no interrupt or identification reports trigger or timeout; queues still run.
// R22 - Line status 5, 6, 7 show queue empty, all empty, error held.
// R23 - Enable bits 0 to 3 gate data, transmit, line and modem interrupts.
// R24 - Timeout counter restarts at zero and counts four full character lengths.
module ums_core
  import ums_pkg::*;
#(
  parameter int NCH = 2
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Modem inputs, active low.
  input wire logic [NCH-1:0] cts_n_i,
  input wire logic [NCH-1:0] dsr_n_i,
  input wire logic [NCH-1:0] ri_n_i,
  input wire logic [NCH-1:0] dcd_n_i,
  // Modem and multi-function outputs, active low.
  output logic [NCH-1:0] dtr_n_o,
  output logic [NCH-1:0] rts_n_o,
  output logic [NCH-1:0] mf_n_o,
  // Receive queue side.
  input wire logic [NCH-1:0] baud_tick_i,
  input wire logic [NCH-1:0][4:0] rx_count_i,
  input wire logic [NCH-1:0][4:0] rx_trig_i,
  input wire logic [NCH-1:0] rx_push_i,
  input wire logic [NCH-1:0][7:0] rx_data_i,
  input wire logic [NCH-1:0] rx_err_fifo_i,
  input wire logic [NCH-1:0][3:0] line_err_i,
  output logic [NCH-1:0] rx_pop_o,
  output logic [NCH-1:0] lsr_read_o,
  // Transmit queue side.
  input wire logic [NCH-1:0][4:0] tx_count_i,
  input wire logic [NCH-1:0] tsr_empty_i,
  output logic [NCH-1:0] tx_push_o,
  output logic [7:0] tx_data_o,
  // Channel configuration and interrupt.
  output logic [NCH-1:0] fifo_en_o,
  output logic [NCH-1:0][7:0] lcr_o,
  output logic [NCH-1:0][15:0] divisor_o,
  output logic [NCH-1:0] intr_o
);

  function automatic logic [3:0] char_bits(input logic [7:0] lcr);
    char_bits = 4'(`UMS_START_BITS + `UMS_WL_BASE + lcr[1:0] + lcr[`UMS_LCR_PAR]
      + `UMS_MIN_STOP_BITS + lcr[`UMS_LCR_STOP]);
  endfunction

  // Bus state.
  ums_bus_st_t bus_st_r, bus_st_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // Channel state.
  logic [NCH-1:0][3:0] ier_r, ier_nxt;
  logic [NCH-1:0][7:0] lcr_r, lcr_nxt;
  logic [NCH-1:0][4:0] mcr_r, mcr_nxt;
  logic [NCH-1:0][2:0] afr_r, afr_nxt;
  logic [NCH-1:0][7:0] scr_r, scr_nxt;
  logic [NCH-1:0][7:0] dll_r, dll_nxt;
  logic [NCH-1:0][7:0] dlm_r, dlm_nxt;
  logic [NCH-1:0] fen_r, fen_nxt;
  logic [NCH-1:0][3:0] lvl_r, lvl_nxt;
  logic [NCH-1:0][3:0] delta_r, delta_nxt;
  logic [NCH-1:0][9:0] tout_cnt_r, tout_cnt_nxt;
  logic [NCH-1:0] tout_r, tout_nxt;
  logic [NCH-1:0] tx_holding_empty_r, tx_holding_empty_nxt;
  logic [NCH-1:0] two_r, two_nxt;
  logic [NCH-1:0] first_r, first_nxt;
  logic [NCH-1:0][7:0] dly_r, dly_nxt;
  logic [NCH-1:0] tx_holding_empty_int_r, tx_holding_empty_int_nxt;
  logic [NCH-1:0] dtr_n_r, dtr_n_nxt;
  logic [NCH-1:0] rts_n_r, rts_n_nxt;
  logic [NCH-1:0] mf_n_r, mf_n_nxt;
  logic [NCH-1:0] intr_r, intr_nxt;
  logic [NCH-1:0] rx_pop_r, rx_pop_nxt;
  logic [NCH-1:0] lsr_rd_r, lsr_rd_nxt;
  logic [NCH-1:0] tx_push_r, tx_push_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;

  // Derived per-channel views.
  logic [NCH-1:0][3:0] eff_lvl;
  logic [NCH-1:0][7:0] msr_v;
  logic [NCH-1:0][7:0] lsr_v;
  logic [NCH-1:0][7:0] iir_v;
  logic [NCH-1:0] receive_ready_out_v;
  logic [NCH-1:0][9:0] tout_lim;
  logic [NCH-1:0][7:0] dly_lim;

  // Access decode.
  logic acc_rd;
  logic acc_wr;
  logic [2:0] areg;
  logic ach;
  logic conc;

  assign acc_rd = (bus_st_r == UMS_BS_DONE) && avs_read_i;
  assign acc_wr = (bus_st_r == UMS_BS_DONE) && avs_write_i && avs_byteenable_i[0];
  assign areg = avs_address_i[`UMS_ADDR_REG_HI:`UMS_ADDR_REG_LO];
  assign ach = avs_address_i[`UMS_ADDR_CH];

  always_comb begin
    conc = 1'h0;
    for (int c = 0; c < NCH; c++) begin
      conc = conc | afr_r[c][`UMS_AFR_CONC]; // see R8
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (mcr_r[c][`UMS_MCR_LOOP]) begin
        eff_lvl[c] = {mcr_r[c][`UMS_MCR_OUT2], mcr_r[c][`UMS_MCR_OUT1],
                      mcr_r[c][`UMS_MCR_DTR], mcr_r[c][`UMS_MCR_RTS]}; // see R6
      end else begin
        eff_lvl[c] = ~{dcd_n_i[c], ri_n_i[c], dsr_n_i[c], cts_n_i[c]}; // see R5
      end
      msr_v[c] = {lvl_r[c], delta_r[c]};
      lsr_v[c] = {fen_r[c] & rx_err_fifo_i[c], tx_holding_empty_r[c] & tsr_empty_i[c], tx_holding_empty_r[c],
                  line_err_i[c], rx_count_i[c] != 5'h00}; // see R15, R22
      tout_lim[c] = 10'(`UMS_TOUT_CHARS * `UMS_TICKS_PER_BIT * char_bits(lcr_r[c])); // see R24
      dly_lim[c] = 8'((char_bits(lcr_r[c]) - 4'h1) * `UMS_TICKS_PER_BIT); // see R20
      if (fen_r[c]) begin
        receive_ready_out_v[c] = (rx_count_i[c] >= rx_trig_i[c]) || tout_r[c];
      end else begin
        receive_ready_out_v[c] = rx_count_i[c] != 5'h00;
      end
      // Fixed priority: line status, received data, timeout, transmit empty, modem.
      iir_v[c] = {fen_r[c], fen_r[c], 2'h0, `UMS_IIR_NONE};
      if (ier_r[c][`UMS_IER_MS] && (delta_r[c] != 4'h0)) begin
        iir_v[c][3:0] = `UMS_IIR_MS; // see R4, R23
      end
      if (ier_r[c][`UMS_IER_TX] && tx_holding_empty_int_r[c]) begin
        iir_v[c][3:0] = `UMS_IIR_TX_HOLDING_EMPTY; // see R23
      end
      if (ier_r[c][`UMS_IER_RX] && fen_r[c] && tout_r[c]) begin
        iir_v[c][3:0] = `UMS_IIR_TOUT; // see R16, R21
      end
      if (ier_r[c][`UMS_IER_RX] && (fen_r[c] ? rx_count_i[c] >= rx_trig_i[c] : rx_count_i[c] != 5'h00)) begin
        iir_v[c][3:0] = `UMS_IIR_RDA; // see R13, R21
      end
      if (ier_r[c][`UMS_IER_LS] && (line_err_i[c] != 4'h0)) begin
        iir_v[c][3:0] = `UMS_IIR_LS; // see R14
      end
    end
  end

  // Bus slave: one wait state, read data captured as waitrequest falls.
  always_comb begin
    bus_st_nxt = bus_st_r;
    wait_nxt = wait_r;
    rdata_nxt = rdata_r;
    unique case (bus_st_r)
      UMS_BS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          bus_st_nxt = UMS_BS_DONE;
          wait_nxt = 1'h0;
          rdata_nxt = 32'h0000_0000;
          unique case (areg)
            `UMS_REG_DATA: rdata_nxt[7:0] = lcr_r[ach][`UMS_LCR_DIVISOR_LATCH_ACCESS] ? dll_r[ach] : rx_data_i[ach];
            `UMS_REG_IER: rdata_nxt[7:0] = lcr_r[ach][`UMS_LCR_DIVISOR_LATCH_ACCESS] ? dlm_r[ach] : {4'h0, ier_r[ach]};
            `UMS_REG_IIR: rdata_nxt[7:0] = lcr_r[ach][`UMS_LCR_DIVISOR_LATCH_ACCESS] ? {5'h00, afr_r[ach]} : iir_v[ach]; // see R7, R11
            `UMS_REG_LCR: rdata_nxt[7:0] = lcr_r[ach];
            `UMS_REG_MCR: rdata_nxt[7:0] = {3'h0, mcr_r[ach]};
            `UMS_REG_LSR: rdata_nxt[7:0] = lsr_v[ach];
            `UMS_REG_MSR: rdata_nxt[7:0] = msr_v[ach];
            `UMS_REG_SCR: rdata_nxt[7:0] = scr_r[ach]; // see R12
          endcase
        end
      end
      UMS_BS_DONE: begin
        bus_st_nxt = UMS_BS_IDLE;
        wait_nxt = 1'h1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_st_r <= UMS_BS_IDLE;
      wait_r <= 1'h1;
      rdata_r <= 32'h0000_0000;
    end else begin
      bus_st_r <= bus_st_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    ier_nxt = ier_r;
    lcr_nxt = lcr_r;
    mcr_nxt = mcr_r;
    afr_nxt = afr_r;
    scr_nxt = scr_r;
    dll_nxt = dll_r;
    dlm_nxt = dlm_r;
    fen_nxt = fen_r;
    lvl_nxt = eff_lvl;
    delta_nxt = delta_r;
    tout_cnt_nxt = tout_cnt_r;
    tout_nxt = tout_r;
    tx_holding_empty_nxt = tx_holding_empty_r;
    two_nxt = two_r;
    first_nxt = first_r;
    dly_nxt = dly_r;
    tx_holding_empty_int_nxt = tx_holding_empty_int_r;
    dtr_n_nxt = dtr_n_r;
    rts_n_nxt = rts_n_r;
    mf_n_nxt = mf_n_r;
    intr_nxt = intr_r;
    rx_pop_nxt = '0;
    lsr_rd_nxt = '0;
    tx_push_nxt = '0;
    tx_data_nxt = tx_data_r;
    for (int c = 0; c < NCH; c++) begin
      logic wsel;
      logic rsel;
      logic divisor_latch_access;
      logic pop_ev;
      logic thr_wr;
      logic iir_tx_holding_empty_rd;
      logic [3:0] dset;
      logic [3:0] dclr;
      wsel = acc_wr && ((ach == 1'(c)) || conc); // see R8
      rsel = acc_rd && (ach == 1'(c));
      divisor_latch_access = lcr_r[c][`UMS_LCR_DIVISOR_LATCH_ACCESS];
      pop_ev = rsel && (areg == `UMS_REG_DATA) && !divisor_latch_access;
      thr_wr = wsel && (areg == `UMS_REG_DATA) && !divisor_latch_access;
      iir_tx_holding_empty_rd = rsel && (areg == `UMS_REG_IIR) && !divisor_latch_access && (rdata_r[3:0] == `UMS_IIR_TX_HOLDING_EMPTY);
      rx_pop_nxt[c] = pop_ev;
      lsr_rd_nxt[c] = rsel && (areg == `UMS_REG_LSR);
      tx_push_nxt[c] = thr_wr;
      if (thr_wr) begin
        tx_data_nxt = avs_writedata_i[7:0];
      end
      if (wsel) begin
        unique case (areg)
          `UMS_REG_DATA: begin
            if (divisor_latch_access) begin
              dll_nxt[c] = avs_writedata_i[7:0];
            end
          end
          `UMS_REG_IER: begin
            if (divisor_latch_access) begin
              dlm_nxt[c] = avs_writedata_i[7:0];
            end else begin
              ier_nxt[c] = avs_writedata_i[3:0];
            end
          end
          `UMS_REG_IIR: begin
            if (divisor_latch_access) begin
              afr_nxt[c] = avs_writedata_i[2:0]; // see R7, R11
            end else begin
              fen_nxt[c] = avs_writedata_i[`UMS_FCR_EN];
            end
          end
          `UMS_REG_LCR: lcr_nxt[c] = avs_writedata_i[7:0];
          `UMS_REG_MCR: mcr_nxt[c] = avs_writedata_i[4:0];
          `UMS_REG_SCR: scr_nxt[c] = avs_writedata_i[7:0]; // see R12
          default: begin
          end
        endcase
      end
      // Change flags: only bits the read actually returned are cleared, and a new change wins.
      dset[0] = eff_lvl[c][0] ^ lvl_r[c][0]; // see R1
      dset[1] = eff_lvl[c][1] ^ lvl_r[c][1]; // see R1
      dset[2] = lvl_r[c][2] & ~eff_lvl[c][2]; // see R2
      dset[3] = eff_lvl[c][3] ^ lvl_r[c][3]; // see R1
      dclr = (rsel && (areg == `UMS_REG_MSR)) ? rdata_r[3:0] : 4'h0; // see R3
      delta_nxt[c] = dset | (delta_r[c] & ~dclr);
      // Receive timeout on baud ticks.
      if (pop_ev || (!tout_r[c] && rx_push_i[c])) begin
        tout_cnt_nxt[c] = 10'h000; // see R18, R24
        if (pop_ev) begin
          tout_nxt[c] = 1'h0; // see R18
        end
      end else if (rx_count_i[c] == 5'h00) begin
        tout_cnt_nxt[c] = 10'h000;
        tout_nxt[c] = 1'h0;
      end else if (tout_cnt_r[c] >= tout_lim[c]) begin
        tout_nxt[c] = fen_r[c]; // see R16
      end else if (baud_tick_i[c]) begin
        tout_cnt_nxt[c] = tout_cnt_r[c] + 10'h001; // see R17
      end
      // Transmit empty with optional delay of one character less one stop bit.
      if (fen_nxt[c] != fen_r[c]) begin
        first_nxt[c] = 1'h1; // see R20
      end
      if (tx_count_i[c] >= 5'h02) begin
        two_nxt[c] = 1'h1;
      end
      if (tx_count_i[c] != 5'h00) begin
        tx_holding_empty_nxt[c] = 1'h0;
        dly_nxt[c] = 8'h00;
      end else if (!tx_holding_empty_r[c]) begin
        if (!fen_r[c] || two_r[c] || first_r[c]) begin
          tx_holding_empty_nxt[c] = 1'h1; // see R20
        end else if (baud_tick_i[c]) begin
          if (dly_nxt[c] >= dly_lim[c] - 8'h01) begin
            tx_holding_empty_nxt[c] = 1'h1; // see R20
          end else begin
            dly_nxt[c] = dly_r[c] + 8'h01;
          end
        end
      end
      if (tx_holding_empty_nxt[c] && !tx_holding_empty_r[c]) begin
        two_nxt[c] = 1'h0;
        first_nxt[c] = 1'h0;
        dly_nxt[c] = 8'h00;
      end
      if (thr_wr || iir_tx_holding_empty_rd || !ier_nxt[c][`UMS_IER_TX]) begin
        tx_holding_empty_int_nxt[c] = 1'h0; // see R19
      end
      if (ier_nxt[c][`UMS_IER_TX] && ((tx_holding_empty_nxt[c] && !tx_holding_empty_r[c])
          || (tx_holding_empty_r[c] && !ier_r[c][`UMS_IER_TX]))) begin
        tx_holding_empty_int_nxt[c] = 1'h1; // see R19
      end
      // Pins.
      if (mcr_r[c][`UMS_MCR_LOOP]) begin
        dtr_n_nxt[c] = 1'h1;
        rts_n_nxt[c] = 1'h1;
      end else begin
        dtr_n_nxt[c] = ~mcr_r[c][`UMS_MCR_DTR];
        rts_n_nxt[c] = ~mcr_r[c][`UMS_MCR_RTS];
      end
      unique case (afr_r[c][`UMS_AFR_SEL_HI:`UMS_AFR_SEL_LO]) // see R10
        `UMS_MF_OUT2: mf_n_nxt[c] = mcr_r[c][`UMS_MCR_LOOP] | ~mcr_r[c][`UMS_MCR_OUT2];
        `UMS_MF_BAUD: mf_n_nxt[c] = ~baud_tick_i[c];
        `UMS_MF_RECEIVE_READY_OUT: mf_n_nxt[c] = ~receive_ready_out_v[c];
        `UMS_MF_HIGH: mf_n_nxt[c] = 1'h1;
      endcase
      intr_nxt[c] = iir_v[c][3:0] != `UMS_IIR_NONE; // see R23
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int c = 0; c < NCH; c++) begin
        ier_r[c] <= `UMS_IER_RST;
        lcr_r[c] <= `UMS_LCR_RST;
        mcr_r[c] <= `UMS_MCR_RST;
        afr_r[c] <= `UMS_AFR_RST;
        scr_r[c] <= `UMS_BYTE_RST;
        dll_r[c] <= `UMS_BYTE_RST;
        dlm_r[c] <= `UMS_BYTE_RST;
        lvl_r[c] <= 4'h0;
        delta_r[c] <= 4'h0;
        tout_cnt_r[c] <= 10'h000;
        dly_r[c] <= 8'h00;
      end
      fen_r <= '0;
      tout_r <= '0;
      tx_holding_empty_r <= '1;
      two_r <= '0;
      first_r <= '1;
      tx_holding_empty_int_r <= '0;
      dtr_n_r <= '1;
      rts_n_r <= '1;
      mf_n_r <= '1;
      intr_r <= '0;
      rx_pop_r <= '0;
      lsr_rd_r <= '0;
      tx_push_r <= '0;
      tx_data_r <= `UMS_BYTE_RST;
    end else begin
      ier_r <= ier_nxt;
      lcr_r <= lcr_nxt;
      mcr_r <= mcr_nxt;
      afr_r <= afr_nxt;
      scr_r <= scr_nxt;
      dll_r <= dll_nxt;
      dlm_r <= dlm_nxt;
      lvl_r <= lvl_nxt;
      delta_r <= delta_nxt;
      tout_cnt_r <= tout_cnt_nxt;
      dly_r <= dly_nxt;
      fen_r <= fen_nxt;
      tout_r <= tout_nxt;
      tx_holding_empty_r <= tx_holding_empty_nxt;
      two_r <= two_nxt;
      first_r <= first_nxt;
      tx_holding_empty_int_r <= tx_holding_empty_int_nxt;
      dtr_n_r <= dtr_n_nxt;
      rts_n_r <= rts_n_nxt;
      mf_n_r <= mf_n_nxt;
      intr_r <= intr_nxt;
      rx_pop_r <= rx_pop_nxt;
      lsr_rd_r <= lsr_rd_nxt;
      tx_push_r <= tx_push_nxt;
      tx_data_r <= tx_data_nxt;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign dtr_n_o = dtr_n_r;
  assign rts_n_o = rts_n_r;
  assign mf_n_o = mf_n_r;
  assign rx_pop_o = rx_pop_r;
  assign lsr_read_o = lsr_rd_r;
  assign tx_push_o = tx_push_r;
  assign tx_data_o = tx_data_r;
  assign fifo_en_o = fen_r;
  assign lcr_o = lcr_r;
  assign intr_o = intr_r;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      divisor_o[c] = {dlm_r[c], dll_r[c]};
    end
  end

endmodule

// ---- verif/ums_core_sva.sv ----
`timescale 1ns/10ps
module ums_core_sva #(
  parameter int NCH = 2
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register bus.
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Queue side pulses and configuration.
  input wire logic [NCH-1:0] rx_pop_o,
  input wire logic [NCH-1:0] lsr_read_o,
  input wire logic [NCH-1:0] tx_push_o,
  input wire logic [7:0] tx_data_o,
  input wire logic [NCH-1:0] fifo_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic acc;
  assign acc = !avs_waitrequest_o;
  property p_answer; (avs_read_i || avs_write_i) |-> ##[0:2] acc; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_one; acc |=> !acc; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_idle; (!avs_read_i && !avs_write_i && !acc) |=> !acc; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_upper; acc |-> avs_readdata_o[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_pop; rx_pop_o[0] |-> $past(acc && avs_read_i && avs_address_i[5:2] == 4'h0) ##1 !rx_pop_o[0];
  endproperty
  a_pop: assert property (p_pop) else $error("stray receive pop");
  property p_lsr; lsr_read_o[0] |-> $past(acc && avs_read_i && avs_address_i[5:2] == 4'h5); endproperty
  a_lsr: assert property (p_lsr) else $error("stray line status read");
  property p_push; tx_push_o[0] |-> $past(acc && avs_write_i) && tx_data_o == $past(avs_writedata_i[7:0]);
  endproperty
  a_push: assert property (p_push) else $error("bad transmit push");
  property p_fen; $changed(fifo_en_o[0]) |-> $past(acc && avs_write_i && avs_address_i[4:2] == 3'h2); endproperty
  a_fen: assert property (p_fen) else $error("fifo enable changed alone");
endmodule

// ---- verif/ums_modem_model.sv ----
`timescale 1ns/10ps
module ums_modem_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Wanted levels {dcd, ri, dsr, cts} per channel, and answer delay.
  input wire logic [7:0] lvl_i,
  input wire logic [3:0] dly_i,
  // Modem pins, active low.
  output logic [1:0] cts_n_o,
  output logic [1:0] dsr_n_o,
  output logic [1:0] ri_n_o,
  output logic [1:0] dcd_n_o
);
  logic [7:0] cur_r;
  logic [7:0] tgt_r;
  logic [3:0] cnt_r;
  // A new level request restarts the delay, so slow and prompt answers both occur.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_r <= 8'hFF;
      tgt_r <= 8'hFF;
      cnt_r <= 4'h0;
    end else if (lvl_i != tgt_r) begin
      tgt_r <= lvl_i;
      cnt_r <= dly_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      cur_r <= tgt_r;
    end
  end
  assign cts_n_o = {cur_r[4], cur_r[0]};
  assign dsr_n_o = {cur_r[5], cur_r[1]};
  assign ri_n_o = {cur_r[6], cur_r[2]};
  assign dcd_n_o = {cur_r[7], cur_r[3]};
endmodule

// ---- verif/uart_modem_status_fifo_interrupts_tb_top.sv ----
`timescale 1ns/10ps
`include "ums_cfg.svh"
module uart_modem_status_fifo_interrupts_tb_top;
  import ums_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] cts_n_i, dsr_n_i, ri_n_i, dcd_n_i, dtr_n_o, rts_n_o, mf_n_o, rx_pop_o, lsr_read_o;
  logic [1:0] baud_tick_i = 2'h0, rx_push_i = 2'h0, rx_err_fifo_i = 2'h0, tsr_empty_i = 2'h3;
  logic [1:0] tx_push_o, fifo_en_o, intr_o;
  logic [1:0][4:0] rx_count_i = '0, rx_trig_i = '0, tx_count_i = '0;
  logic [1:0][7:0] rx_data_i = '0, lcr_o;
  logic [1:0][3:0] line_err_i = '0;
  logic [1:0][15:0] divisor_o;
  logic [7:0] tx_data_o, lvl = 8'hFF, q, v;
  logic [3:0] dly = 4'h0, o, n;
  logic ticks_on = 1'b0;
  int seed = 4282, n_fail = 0, compares = 0, cyc = 0;

  ums_core #(.NCH(2)) dut (.*);
  ums_modem_model u_modem (.clk_i(clk_i), .rst_b_i(rst_b_i), .lvl_i(lvl), .dly_i(dly), .cts_n_o(cts_n_i),
    .dsr_n_o(dsr_n_i), .ri_n_o(ri_n_i), .dcd_n_o(dcd_n_i));

  always #20 clk_i = ~clk_i;
  // Channel 1 baud tick and receive push, and receive data on both channels, run at random to keep that side busy.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    baud_tick_i <= {1'($random(seed)), ticks_on};
    rx_push_i[1] <= 1'($random(seed));
    rx_data_i <= 16'($random(seed));
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic ch, input logic [2:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= {ch, idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      results();
    end
  endtask
  task automatic rd(input logic ch, input logic [2:0] idx, input logic [7:0] e, input string m);
    bus(1'b0, ch, idx, 8'h00);
    chk(q, e, m);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic ck_int(input logic e, input string m);
    chk({7'h0, intr_o[0]}, {7'h0, e}, m);
  endtask
  // Levels are {dcd, ri, dsr, cts} pin values; ring flags only on the pin going high.
  function automatic logic [7:0] msr_exp(input logic [3:0] a, input logic [3:0] b);
    msr_exp = {~b, a[3] ^ b[3], b[2] & ~a[2], a[1] ^ b[1], a[0] ^ b[0]};
  endfunction

  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      bus(1'b1, i[0], `UMS_REG_SCR, v);
      rd(i[0], `UMS_REG_SCR, v, "scratch");
    end
    $display("Test scratch done");
    bus(1'b1, 1'b0, `UMS_REG_LCR, 8'h80);
    bus(1'b1, 1'b1, `UMS_REG_LCR, 8'h80);
    bus(1'b1, 1'b0, `UMS_REG_DATA, 8'h34);
    bus(1'b1, 1'b0, `UMS_REG_IER, 8'h12);
    wt(1);
    chk(divisor_o[0][15:8], 8'h12, "divisor high");
    chk(divisor_o[0][7:0], 8'h34, "divisor low");
    chk(lcr_o[0], 8'h80, "line control");
    bus(1'b1, 1'b0, `UMS_REG_MCR, 8'h08);
    rx_count_i[0] <= 5'd1;
    for (int s = 0; s < 4; s++) begin
      v = 8'($random(seed));
      bus(1'b1, 1'b0, `UMS_REG_IIR, {v[7:3], s[1:0], 1'b0});
      rd(1'b0, `UMS_REG_IIR, {5'h0, s[1:0], 1'b0}, "alt function");
      wt(3);
      chk({7'h0, mf_n_o[0]}, {7'h0, s[0]}, "mf pin");
    end
    bus(1'b1, 1'b0, `UMS_REG_IIR, 8'h01);
    bus(1'b1, 1'b1, `UMS_REG_SCR, 8'h5A);
    rd(1'b0, `UMS_REG_SCR, 8'h5A, "concurrent");
    bus(1'b1, 1'b1, `UMS_REG_IIR, 8'h00);
    bus(1'b1, 1'b0, `UMS_REG_SCR, 8'h11);
    rd(1'b1, `UMS_REG_SCR, 8'h5A, "concurrent off");
    bus(1'b1, 1'b0, `UMS_REG_LCR, 8'h00);
    bus(1'b1, 1'b1, `UMS_REG_LCR, 8'h00);
    $display("Test alternate function done");
    bus(1'b1, 1'b0, `UMS_REG_IER, 8'h08);
    bus(1'b1, 1'b0, `UMS_REG_MCR, 8'h00);
    bus(1'b0, 1'b0, `UMS_REG_MSR, 8'h00);
    o = 4'hF;
    for (int i = 0; i < 8; i++) begin
      n = (i == 0) ? 4'h0 : (i == 1) ? 4'h4 : 4'($random(seed));
      dly <= 4'($random(seed));
      lvl <= {4'($random(seed)), n};
      wt(24);
      v = msr_exp(o, n);
      ck_int(v[3:0] != 4'h0, "modem intr");
      rd(1'b0, `UMS_REG_MSR, v, "modem status");
      rd(1'b0, `UMS_REG_MSR, {~n, 4'h0}, "flags cleared");
      o = n;
    end
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h1A : 8'h15;
      bus(1'b1, 1'b0, `UMS_REG_MCR, v);
      wt(3);
      bus(1'b0, 1'b0, `UMS_REG_MSR, 8'h00);
      chk({4'h0, q[7:4]}, {4'h0, v[3], v[2], v[0], v[1]}, "loopback");
      chk({6'h0, dtr_n_o[0], rts_n_o[0]}, 8'h03, "loop pins");
    end
    bus(1'b1, 1'b0, `UMS_REG_MCR, 8'h00);
    $display("Test modem status done");
    bus(1'b1, 1'b0, `UMS_REG_IIR, 8'h01);
    bus(1'b1, 1'b0, `UMS_REG_IER, 8'h05);
    rx_trig_i[0] <= 5'd4;
    for (int c = 3; c < 5; c++) begin
      rx_count_i[0] <= c[4:0];
      wt(3);
      ck_int(c == 4, "trigger");
    end
    rd(1'b0, `UMS_REG_IIR, 8'hC4, "data ident");
    line_err_i[0] <= 4'h1;
    wt(3);
    rd(1'b0, `UMS_REG_IIR, 8'hC6, "line ident");
    line_err_i[0] <= 4'h0;
    rx_err_fifo_i[0] <= 1'b1;
    wt(2);
    rd(1'b0, `UMS_REG_LSR, 8'hE1, "line status");
    bus(1'b1, 1'b0, `UMS_REG_IER, 8'h00);
    wt(3);
    ck_int(1'b0, "polled");
    rx_err_fifo_i[0] <= 1'b0;
    bus(1'b1, 1'b0, `UMS_REG_IER, 8'h01);
    rx_count_i[0] <= 5'd1;
    rx_push_i[0] <= 1'b1;
    ticks_on <= 1'b1;
    @(posedge clk_i);
    rx_push_i[0] <= 1'b0;
    wt(440);
    ck_int(1'b0, "timeout early");
    wt(20);
    ck_int(1'b1, "timeout late");
    rd(1'b0, `UMS_REG_IIR, 8'hCC, "timeout ident");
    bus(1'b0, 1'b0, `UMS_REG_DATA, 8'h00);
    wt(2);
    ck_int(1'b0, "timeout clear");
    $display("Test receive done");
    ticks_on <= 1'b0;
    rx_count_i[0] <= 5'd0;
    bus(1'b1, 1'b0, `UMS_REG_IER, 8'h02);
    wt(3);
    ck_int(1'b1, "tx empty");
    rd(1'b0, `UMS_REG_IIR, 8'hC2, "tx ident");
    wt(2);
    ck_int(1'b0, "tx cleared");
    // The first empty after the enable toggle is immediate; later ones wait one character less one stop bit.
    tx_count_i[0] <= 5'd1;
    tsr_empty_i[0] <= 1'b0;
    wt(2);
    tx_count_i[0] <= 5'd0;
    wt(2);
    rd(1'b0, `UMS_REG_LSR, 8'h20, "first empty");
    tsr_empty_i[0] <= 1'b1;
    tx_count_i[0] <= 5'd1;
    ticks_on <= 1'b1;
    wt(2);
    tx_count_i[0] <= 5'd0;
    wt(80);
    rd(1'b0, `UMS_REG_LSR, 8'h00, "empty delayed");
    wt(30);
    rd(1'b0, `UMS_REG_LSR, 8'h60, "empty after delay");
    ck_int(1'b1, "tx empty again");
    bus(1'b1, 1'b0, `UMS_REG_DATA, 8'hA5);
    wt(1);
    chk(tx_data_o, 8'hA5, "tx byte");
    chk({7'h0, tx_push_o[0]}, 8'h01, "tx push");
    wt(1);
    ck_int(1'b0, "tx write clear");
    $display("Test transmit done");
    results();
  end
endmodule

bind ums_core ums_core_sva #(.NCH(NCH)) u_sva (.*);
